// ==== bench/mihd_bias_model.sv ====
// Comparator model standing in for the bias current front end
`timescale 1ns/100ps
module mihd_bias_model
  import mihd_pkg::*;
(
  // Clock
  input  wire logic pclk,
  // Wanted current levels
  input  wire logic mic_in,
  input  wire logic hook_in,
  // Comparator outputs
  output mihd_cmp_t cmp
);
  // Registered, so levels only move just after an edge
  always_ff @(posedge pclk) begin
    cmp <= '{mic_above: mic_in, hook_above: hook_in};
  end
endmodule

// ==== bench/mihd_top_asserts.sv ====
// Port checker for the mic insert / hook detect core
`timescale 1ns/100ps
module mihd_top_asserts
  import mihd_pkg::*;
(
  // Watched ports
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire mihd_cmp_t   cmp,
  input wire logic        irq,
  input wire logic        gpio_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;

  a_ready_high: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_err_unmapped: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (
    acc && paddr == MIHD_OFS_STATUS |-> !pslverr)
    else $error("error on mapped access");
  a_read_unmapped: assert property (
    acc && !pwrite && paddr > 8'h10 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_noerr: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  a_mask_off: assert property (acc && pwrite && paddr == MIHD_OFS_MASK
    && pwdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with mask cleared");
  a_irq_sticky: assert property (irq && !(acc && pwrite) |=> irq)
    else $error("irq dropped without a write");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !irq && !gpio_level)
    else $error("outputs not quiet after reset");
endmodule

// ==== bench/test_mihd_top.sv ====
// Register-level testbench for the mic insert / hook detect core
`timescale 1ns/100ps
module test_mihd_top;
  import mihd_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, mic_in = 1'b0, hook_in = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, gpio_level, last_err;
  mihd_cmp_t   cmp;
  int          miscompares = 0, check_count = 0, cycles = 0;

  always #12.5 pclk = ~pclk;
  mihd_top mihd_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp, .irq, .gpio_level);
  mihd_bias_model mihd_bias_model_inst (.pclk, .mic_in, .hook_in, .cmp);

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps two requests from landing in one time step
    @(posedge pclk);
  endtask
  task automatic same(input string what, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    same($sformatf("reg %h", a), e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic drive(input logic m, h, input int n);
    mic_in <= m;
    hook_in <= h;
    repeat (n) @(posedge pclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict;
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    same("gpio", 32'h0, {31'h0, gpio_level});
    chk(MIHD_OFS_CTRL, 32'h0);
    chk(MIHD_OFS_CFG, 32'h28);
    // Two cycles a sample keeps bounce counts clear of edge effects
    wr(MIHD_OFS_CFG, 32'h2);
    wr(MIHD_OFS_MASK, 32'h3);
    wr(MIHD_OFS_CTRL, 32'h2);
    drive(1'b1, 1'b0, 5);
    drive(1'b0, 1'b0, 10);
    chk(MIHD_OFS_STATUS, 32'h0);
    drive(1'b1, 1'b0, 40);
    chk(MIHD_OFS_STATUS, 32'h1);
    same("irq", 32'h1, {31'h0, irq});
    wr(MIHD_OFS_CTRL, 32'h3);
    wr(MIHD_OFS_STATUS, 32'h1);
    chk(MIHD_OFS_LEVEL, 32'h1);
    same("gpio", 32'h1, {31'h0, gpio_level});
    wr(MIHD_OFS_CTRL, 32'h1);
    drive(1'b1, 1'b1, 17);
    drive(1'b1, 1'b0, 20);
    chk(MIHD_OFS_STATUS, 32'h0);
    drive(1'b1, 1'b1, 40);
    chk(MIHD_OFS_STATUS, 32'h2);
    chk(MIHD_OFS_LEVEL, 32'h3);
    wr(MIHD_OFS_CTRL, 32'h5);
    wr(MIHD_OFS_STATUS, 32'h2);
    drive(1'b1, 1'b0, 17);
    drive(1'b1, 1'b1, 20);
    chk(MIHD_OFS_STATUS, 32'h0);
    drive(1'b1, 1'b0, 40);
    chk(MIHD_OFS_STATUS, 32'h2);
    wr(MIHD_OFS_CTRL, 32'h9);
    wr(MIHD_OFS_STATUS, 32'h2);
    drive(1'b1, 1'b1, 25);
    drive(1'b1, 1'b0, 20);
    chk(MIHD_OFS_STATUS, 32'h0);
    drive(1'b1, 1'b1, 60);
    drive(1'b0, 1'b1, 20);
    chk(MIHD_OFS_STATUS, 32'h3);
    // Level pin switched to the hook side, which is still pressed
    wr(MIHD_OFS_CTRL, 32'h18);
    wr(MIHD_OFS_MASK, 32'h0);
    same("gpio", 32'h1, {31'h0, gpio_level});
    same("irq", 32'h0, {31'h0, irq});
    wr(MIHD_OFS_STATUS, 32'h3);
    chk(MIHD_OFS_STATUS, 32'h0);
    same("pslverr", 32'h0, {31'h0, last_err});
    chk(8'h14, 32'h0);
    same("pslverr", 32'h1, {31'h0, last_err});
    print_verdict;
  end
endmodule

bind mihd_top mihd_top_asserts mihd_top_asserts_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .cmp, .irq, .gpio_level);

// ==== hdl/mihd_filter.sv ====
// Consecutive-sample filter for one comparator level
`timescale 1ns/100ps
module mihd_filter
  import mihd_pkg::*;
#(
  parameter int BASE_N = MIHD_HOOK_SAMPLES,
  parameter int DB_N   = MIHD_DB_SAMPLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Sampling
  input  wire logic tick,
  input  wire logic raw,
  input  wire logic db_en,
  // Filtered level and change pulse
  output logic      steady,
  output logic      change
);

  typedef struct packed {
    logic                  steady;
    logic                  change;
    logic [MIHD_CNT_W-1:0] cnt;
  } mihd_flt_t;

  mihd_flt_t st;
  mihd_flt_t next_st;
  logic [MIHD_CNT_W-1:0] need;

  always_comb begin
    need = db_en ? MIHD_CNT_W'(BASE_N + DB_N) : MIHD_CNT_W'(BASE_N);
    next_st        = st;
    next_st.change = 1'b0;
    if (tick) begin
      if (raw == st.steady) begin
        next_st.cnt = '0;
      end else if (st.cnt + 1'b1 >= need) begin
        // Run long enough: accept the new level
        next_st.steady = raw;
        next_st.change = 1'b1;
        next_st.cnt    = '0;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign steady = st.steady;
  assign change = st.change;

endmodule

// ==== hdl/mihd_pkg.sv ====
// Package: constants and carrier types for mic insert / hook detect
package mihd_pkg;

  // Register byte offsets
  localparam logic [7:0] MIHD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MIHD_OFS_STATUS = 8'h04;
  localparam logic [7:0] MIHD_OFS_MASK   = 8'h08;
  localparam logic [7:0] MIHD_OFS_LEVEL  = 8'h0c;
  localparam logic [7:0] MIHD_OFS_CFG    = 8'h10;

  // Control field positions
  localparam int MIHD_CTRL_MIC_POL  = 0;
  localparam int MIHD_CTRL_MIC_DB   = 1;
  localparam int MIHD_CTRL_HOOK_POL = 2;
  localparam int MIHD_CTRL_HOOK_DB  = 3;
  localparam int MIHD_CTRL_GPIO_SEL = 4;

  // Status / mask bit positions
  localparam int MIHD_EV_MIC  = 0;
  localparam int MIHD_EV_HOOK = 1;

  // Reset values
  localparam logic [4:0]  MIHD_CTRL_RST = 5'h00;
  localparam logic [1:0]  MIHD_MASK_RST = 2'h0;
  localparam logic [15:0] MIHD_DIV_RST  = 16'h0028;

  // Sample and debounce counts
  localparam int          MIHD_HOOK_SAMPLES = 10;
  localparam int          MIHD_DB_SAMPLES   = 4;
  localparam int          MIHD_CNT_W        = 5;

  // Time base: 40 MHz, 1 us default sample tick
  localparam int MIHD_CLK_HZ      = 40_000_000;
  localparam int MIHD_TICK_NS     = 1000;
  localparam int MIHD_TICK_CYCLES = (MIHD_TICK_NS * (MIHD_CLK_HZ / 1_000_000))
                                    / 1000;

  // First member is the top bit: listed from bit 4 down to bit 0
  typedef struct packed {
    logic gpio_show_hook;
    logic hook_press_debounce_en;
    logic hook_press_irq_polarity;
    logic mic_present_debounce_en;
    logic mic_present_irq_polarity;
  } mihd_ctrl_t;

  typedef struct packed {
    logic mic_above;
    logic hook_above;
  } mihd_cmp_t;

endpackage

// ==== hdl/mihd_top.sv ====
// Mic insert / hook switch detect core with APB registers
//
// Contract
// [R1] Host polls status at every sequence step
// [R2] Host clears mic polarity before insertion
// [R3] Mic debounce bit lengthens presence filtering
// [R4] Host flips mic polarity, then clears flag
// [R5] Host arms hook press with polarity 0
// [R6] Press flag needs ten samples above threshold
// [R7] Release flag needs ten samples below threshold
// [R8] Hook debounce bit adds extra filtering
// [R9] Host sets hook polarity 1 after press
// [R10] Host sets hook polarity 0 after release
// [R11] Host clears mic polarity after removal
// [R12] GPIO shows steady state, same delays
// [R13] Polarity 0 flags rise, 1 flags fall
// [R14] Flags stay set until host clears
`timescale 1ns/100ps
module mihd_top
  import mihd_pkg::*;
#(
  parameter int MIC_BASE_N  = 1,
  parameter int HOOK_BASE_N = MIHD_HOOK_SAMPLES,
  parameter int DB_N        = MIHD_DB_SAMPLES
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator levels from bias current sensing
  input  wire mihd_cmp_t   cmp,
  // Interrupt and GPIO level
  output logic             irq,
  output logic             gpio_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mihd_ctrl_t  ctrl;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] div;
    logic [15:0] tick_cnt;
    logic        tick;
    logic [31:0] rdata;
    logic        gpio;
  } mihd_state_t;

  mihd_state_t st;
  mihd_state_t next_st;

  localparam int NCH = 2;

  // Per-channel comparator path, indexed by status bit
  logic [NCH-1:0] raw_lvl;
  logic [NCH-1:0] db_sel;
  logic [NCH-1:0] pol_sel;
  logic [NCH-1:0] lvl_steady;
  logic [NCH-1:0] lvl_change;
  logic [NCH-1:0] ev;
  // Flag update
  logic [NCH-1:0] flag_next;

  // Bus decode
  logic           wr;
  logic           rd;
  logic           hit;
  logic           wr_ctrl;
  logic           wr_status;
  logic           wr_mask;
  logic           wr_cfg;
  logic [1:0]     clr_bits;
  logic [31:0]    rd_word;

  // Sample tick
  logic           tick_due;

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  // Channel inputs gathered so both detectors share one loop
  assign raw_lvl[MIHD_EV_MIC]  = cmp.mic_above;
  assign raw_lvl[MIHD_EV_HOOK] = cmp.hook_above;
  assign db_sel[MIHD_EV_MIC]   = st.ctrl.mic_present_debounce_en; // [R3]
  assign db_sel[MIHD_EV_HOOK]  = st.ctrl.hook_press_debounce_en;  // [R8]
  assign pol_sel[MIHD_EV_MIC]  = st.ctrl.mic_present_irq_polarity;
  assign pol_sel[MIHD_EV_HOOK] = st.ctrl.hook_press_irq_polarity;

  for (genvar i = 0; i < NCH; i++) begin : g_chan
    // Hook needs ten samples in a row before a change  [R6] [R7]
    localparam int BASE = (i == MIHD_EV_HOOK) ? HOOK_BASE_N : MIC_BASE_N;

    mihd_filter #(
      .BASE_N (BASE),
      .DB_N   (DB_N)
    ) u_flt (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (st.tick),
      .raw     (raw_lvl[i]),
      .db_en   (db_sel[i]),
      .steady  (lvl_steady[i]),
      .change  (lvl_change[i])
    );

    // Edge direction picked by polarity: rise on 0, fall on 1
    assign ev[i] = lvl_change[i] && (lvl_steady[i] != pol_sel[i]); // [R13]

    // Set beats a clear in the same cycle  [R14]
    assign flag_next[i] = ev[i] || (st.status[i] && !clr_bits[i]);
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && !penable && !pwrite;
  assign hit = (paddr == MIHD_OFS_CTRL)  || (paddr == MIHD_OFS_STATUS) ||
               (paddr == MIHD_OFS_MASK)  || (paddr == MIHD_OFS_LEVEL)  ||
               (paddr == MIHD_OFS_CFG);

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  // Writes land only in the access phase
  assign wr_ctrl   = wr && (paddr == MIHD_OFS_CTRL);
  assign wr_status = wr && (paddr == MIHD_OFS_STATUS);
  assign wr_mask   = wr && (paddr == MIHD_OFS_MASK);
  assign wr_cfg    = wr && (paddr == MIHD_OFS_CFG);
  // Write-one-to-clear mask for the flag bits
  assign clr_bits  = wr_status ? pwdata[1:0] : 2'h0;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Read word chosen in setup, held through the access phase
  always_comb begin
    case (paddr)
      MIHD_OFS_CTRL:   rd_word = {27'h0, st.ctrl};
      MIHD_OFS_STATUS: rd_word = {30'h0, st.status};
      MIHD_OFS_MASK:   rd_word = {30'h0, st.mask};
      MIHD_OFS_LEVEL:  rd_word = {30'h0, lvl_steady};
      MIHD_OFS_CFG:    rd_word = {16'h0, st.div};
      default:         rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  // Compare the incremented count so a divide of one ticks every cycle
  assign tick_due = (st.tick_cnt + 16'h0001) >= st.div;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.tick = tick_due;
    if (tick_due) begin
      next_st.tick_cnt = 16'h0000;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end
    // Read data captured in setup phase
    if (rd) begin
      next_st.rdata = rd_word;
    end
    if (wr_ctrl) begin
      next_st.ctrl = mihd_ctrl_t'(pwdata[4:0]);
    end
    if (wr_mask) begin
      next_st.mask = pwdata[1:0];
    end
    // A zero divide would tick every cycle, the same as one, so it reads as one
    if (wr_cfg) begin
      next_st.div = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
    // Flags held until cleared by the host  [R14]
    next_st.status = flag_next;
    // Steady state, filtered like the flags  [R12]
    next_st.gpio = st.ctrl.gpio_show_hook ? lvl_steady[MIHD_EV_HOOK]
                                          : lvl_steady[MIHD_EV_MIC];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.ctrl     <= mihd_ctrl_t'(MIHD_CTRL_RST);
      st.mask     <= MIHD_MASK_RST;
      st.div      <= MIHD_DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait state keeps the host polling loop cheap
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !hit;
  assign prdata     = st.rdata;

  // ----------------------------------------------------------------
  // Interrupt and level
  // ----------------------------------------------------------------
  // Level, not pulse, so a slow poll never misses an event
  assign irq        = |(st.status & st.mask);
  assign gpio_level = st.gpio;

endmodule
